//--- design/srq_top.sv
// Serial receive stats and transmit queue watermark register bank on an AXI4-Lite slave.
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`include "srq_regs.svh"
module srq_top
  import srq_pkg::*;
#(
  parameter int FILL_W = 24  // Width of the transmit queue fill level in bytes.
) (
  // Clock and reset.
  input  wire logic                   CLOCK,
  input  wire logic                   RST_N,
  // AXI4-Lite write address channel.
  input  wire logic [`SRQ_ADDR_W-1:0] AWADDR,
  input  wire logic                   AWVALID,
  output logic                        AWREADY,
  // AXI4-Lite write data channel.
  input  wire logic [31:0]            WDATA,
  input  wire logic [3:0]             WSTRB,
  input  wire logic                   WVALID,
  output logic                        WREADY,
  // AXI4-Lite write response channel.
  output logic [1:0]                  BRESP,
  output logic                        BVALID,
  input  wire logic                   BREADY,
  // AXI4-Lite read address channel.
  input  wire logic [`SRQ_ADDR_W-1:0] ARADDR,
  input  wire logic                   ARVALID,
  output logic                        ARREADY,
  // AXI4-Lite read data channel.
  output logic [31:0]                 RDATA,
  output logic [1:0]                  RRESP,
  output logic                        RVALID,
  input  wire logic                   RREADY,
  // Receive packet writer events.
  input  wire logic                   ABORT_BYTE,
  // Received X.86 header and its expected values.
  input  wire logic                   HDR_VALID,
  input  wire srq_x86_hdr_t           HDR_RX,
  input  wire srq_x86_hdr_t           HDR_EXPECTED,
  // Transmit queue state from the queue manager.
  input  wire logic                   HDLC_FIFO_OVERFLOW,
  input  wire logic                   QUEUE_OVERFLOW,
  input  wire logic [FILL_W-1:0]      QUEUE_FILL,
  // Interrupt.
  output logic                        IRQ
);

  // ==========================================================================
  // Declarations.
  // ==========================================================================
  logic [`SRQ_ADDR_W-1:0] aw_addr;           // Captured write address.
  logic                   aw_full;           // Write address held.
  logic [31:0]            w_data;            // Captured write data.
  logic                   w_lane0;           // Byte lane 0 was strobed.
  logic                   w_full;            // Write data held.
  logic                   do_write;          // Both halves present, perform write.
  logic [9:0]             w_idx;             // Register index of the write.
  logic [9:0]             r_idx;             // Register index of the read.
  logic                   do_read;           // Read address handshake.
  logic [31:0]            next_rdata;        // Read mux output.
  logic                   r_hit;             // Read index is mapped.
  logic                   w_hit;             // Write index is mapped.
  logic                   wr_lane;           // Write that really stores.
  logic                   snap_request;      // Snapshot control bit.
  logic                   snap_request_prev; // Control bit one cycle ago.
  logic                   snap_take;         // Rising edge of the control bit.
  srq_snap_state_t        snap_state;        // Snapshot sequencer.
  logic                   snap_done;         // Snapshot done flag.
  logic [31:0]            abort_running;     // Running aborted byte count.
  logic [31:0]            abort_snapshot;    // Readable aborted byte count.
  srq_status_t            hdr_enable;        // Header mismatch interrupt enables.
  srq_status_t            queue_enable;      // Queue event interrupt enables.
  logic [7:0]             low_wm_reg;        // Low watermark threshold value.
  logic [7:0]             high_wm_reg;       // High watermark threshold value.
  logic [FILL_W-1:0]      low_wm_bytes;      // Low watermark byte position.
  logic [FILL_W-1:0]      high_wm_bytes;     // High watermark byte position.
  logic                   above_low;         // Fill at or above low watermark.
  logic                   above_high;        // Fill at or above high watermark.
  logic                   above_low_prev;    // Previous low comparison.
  logic                   above_high_prev;   // Previous high comparison.
  srq_status_t            hdr_set;           // Header mismatch events.
  srq_status_t            hdr_clear;         // Header status clears.
  srq_status_t            hdr_status;        // Header mismatch sticky bits.
  srq_status_t            queue_set;         // Queue events.
  srq_status_t            queue_clear;       // Queue status clears.
  srq_status_t            queue_status;      // Queue sticky bits.
  srq_status_t            hdr_wclear;        // Header clears from the clear register.
  srq_status_t            queue_wclear;      // Queue clears from the clear register.

  // ==========================================================================
  // AXI4-Lite write path.
  // ==========================================================================
  // Address and data are taken independently; each is refused while its
  // holding register is full or a response is still waiting.
  assign AWREADY  = !aw_full && !BVALID;
  assign WREADY   = !w_full && !BVALID;
  assign do_write = aw_full && w_full && !BVALID;
  assign w_idx    = aw_addr[`SRQ_ADDR_W-1:`SRQ_IDX_LSB];

  // Hold the write address until the write is performed.
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      aw_addr <= '0;
      aw_full <= 1'b0;
    end else if (AWVALID && AWREADY) begin
      aw_addr <= AWADDR;
      aw_full <= 1'b1;
    end else if (do_write) begin
      aw_full <= 1'b0;
    end
  end

  // Hold the write data until the write is performed.
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      w_data  <= 32'h0000_0000;
      w_lane0 <= 1'b0;
      w_full  <= 1'b0;
    end else if (WVALID && WREADY) begin
      w_data  <= WDATA;
      w_lane0 <= WSTRB[0];
      w_full  <= 1'b1;
    end else if (do_write) begin
      w_full  <= 1'b0;
    end
  end

  // Decode which write indices exist; read-only ones still answer OKAY.
  always_comb begin
    case (w_idx)
      `SRQ_IDX_ABORT_TOP, `SRQ_IDX_SNAP_CTRL, `SRQ_IDX_SNAP_DONE,
      `SRQ_IDX_HDR_STATUS, `SRQ_IDX_HDR_ENABLE, `SRQ_IDX_LOW_WM,
      `SRQ_IDX_HIGH_WM, `SRQ_IDX_QUEUE_ENABLE, `SRQ_IDX_QUEUE_STATUS,
      `SRQ_IDX_STATUS_CLEAR: w_hit = 1'b1;
      default:               w_hit = 1'b0;
    endcase
  end

  // Registers live in byte lane 0; a write without that lane stores nothing.
  assign wr_lane = do_write && w_lane0;

  // Write response follows the performed write by one cycle.
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      BVALID <= 1'b0;
      BRESP  <= `SRQ_RESP_OKAY;
    end else if (do_write) begin
      BVALID <= 1'b1;
      BRESP  <= w_hit ? `SRQ_RESP_OKAY : `SRQ_RESP_SLVERR;
    end else if (BREADY) begin
      BVALID <= 1'b0;
    end
  end

  // ==========================================================================
  // Software-written registers.
  // ==========================================================================
  // Enables and thresholds; only the low four enable bits exist.
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      hdr_enable   <= '0;
      queue_enable <= '0;
      low_wm_reg   <= `SRQ_REG_RESET;
      high_wm_reg  <= `SRQ_REG_RESET;
    end else if (wr_lane) begin
      case (w_idx)
        `SRQ_IDX_HDR_ENABLE:   hdr_enable   <= w_data[`SRQ_STATUS_BITS-1:0];
        `SRQ_IDX_QUEUE_ENABLE: queue_enable <= w_data[`SRQ_STATUS_BITS-1:0];
        `SRQ_IDX_LOW_WM:       low_wm_reg   <= w_data[7:0];
        `SRQ_IDX_HIGH_WM:      high_wm_reg  <= w_data[7:0];
        default: begin
        end
      endcase
    end
  end

  // Snapshot control bit.
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      snap_request <= 1'b0;
    end else if (wr_lane && (w_idx == `SRQ_IDX_SNAP_CTRL)) begin
      snap_request <= w_data[0];
    end
  end

  // The clear register is write-only; a one clears the matching sticky bit.
  assign hdr_wclear   = (wr_lane && (w_idx == `SRQ_IDX_STATUS_CLEAR)) ?
                        w_data[`SRQ_CLEAR_HDR_LSB +: `SRQ_STATUS_BITS] : '0;
  assign queue_wclear = (wr_lane && (w_idx == `SRQ_IDX_STATUS_CLEAR)) ?
                        w_data[`SRQ_CLEAR_QUEUE_LSB +: `SRQ_STATUS_BITS] : '0;

  // ==========================================================================
  // Counter snapshot sequencer.
  // ==========================================================================
  // Edge detect on the control bit; holding it high asks for nothing more.
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      snap_request_prev <= 1'b0;
    end else begin
      snap_request_prev <= snap_request;
    end
  end

  assign snap_take = snap_request && !snap_request_prev;

  // Done goes high the cycle after the copy and stays until software
  // drops the control bit; a new request needs the bit back at zero.
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      snap_state <= SRQ_SNAP_IDLE;
      snap_done  <= 1'b0;
    end else begin
      case (snap_state)
        SRQ_SNAP_IDLE: begin
          if (snap_take) begin
            snap_state <= SRQ_SNAP_DONE;
          end
        end
        SRQ_SNAP_DONE: begin
          snap_done  <= 1'b1;
          snap_state <= SRQ_SNAP_WAIT;
        end
        SRQ_SNAP_WAIT: begin
          if (!snap_request) begin
            snap_done  <= 1'b0;
            snap_state <= SRQ_SNAP_IDLE;
          end
        end
        default: begin
          snap_state <= SRQ_SNAP_IDLE;
          snap_done  <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================================================
  // Aborted byte counter.
  // ==========================================================================
  // Every byte of a packet stored with an abort mark counts, including any
  // bytes the writer flags when dropping for FCS removal, loopback, reset or
  // overflow. A byte arriving on the snapshot cycle starts the new period.
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      abort_running  <= `SRQ_COUNT_RESET;
      abort_snapshot <= `SRQ_COUNT_RESET;
    end else if (snap_take) begin
      abort_snapshot <= abort_running;
      abort_running  <= {31'h0000_0000, ABORT_BYTE};
    end else if (ABORT_BYTE) begin
      abort_running  <= abort_running + 32'h0000_0001;
    end
  end

  // ==========================================================================
  // X.86 header mismatch events.
  // ==========================================================================
  // Each field is checked only on the cycle a header is presented.
  assign hdr_set[3] = HDR_VALID && (HDR_RX.sapi_high != HDR_EXPECTED.sapi_high);
  assign hdr_set[2] = HDR_VALID && (HDR_RX.sapi_low != HDR_EXPECTED.sapi_low);
  assign hdr_set[1] = HDR_VALID && (HDR_RX.control != HDR_EXPECTED.control);
  assign hdr_set[0] = HDR_VALID && (HDR_RX.address != HDR_EXPECTED.address);

  // A read of the status register clears all of it.
  assign hdr_clear = hdr_wclear |
                     {`SRQ_STATUS_BITS{do_read && (r_idx == `SRQ_IDX_HDR_STATUS)}};

  srq_event_latch #(
    .W          (`SRQ_STATUS_BITS)
  ) u_hdr_latch (
    .clock      (CLOCK),
    .rst_n      (RST_N),
    .set_bits   (hdr_set),
    .clear_bits (hdr_clear),
    .status     (hdr_status)
  );

  // ==========================================================================
  // Transmit queue watermarks and overflow events.
  // ==========================================================================
  // The queue is the serial-to-Ethernet buffer; each threshold step is
  // 32 packets of 2048 bytes, a shift by sixteen.
  assign low_wm_bytes  = FILL_W'({low_wm_reg, 16'h0000});
  assign high_wm_bytes = FILL_W'({high_wm_reg, 16'h0000});
  assign above_low     = (QUEUE_FILL >= low_wm_bytes);
  assign above_high    = (QUEUE_FILL >= high_wm_bytes);

  // Previous comparisons reset high, matching an empty queue against a zero
  // threshold, so no crossing is reported out of reset. Moving a threshold
  // past the current fill counts as a crossing.
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      above_low_prev  <= 1'b1;
      above_high_prev <= 1'b1;
    end else begin
      above_low_prev  <= above_low;
      above_high_prev <= above_high;
    end
  end

  // A crossing is a change of side in either direction.
  assign queue_set[3] = HDLC_FIFO_OVERFLOW;
  assign queue_set[2] = QUEUE_OVERFLOW;
  assign queue_set[1] = above_high != above_high_prev;
  assign queue_set[0] = above_low != above_low_prev;

  assign queue_clear = queue_wclear |
                       {`SRQ_STATUS_BITS{do_read && (r_idx == `SRQ_IDX_QUEUE_STATUS)}};

  srq_event_latch #(
    .W          (`SRQ_STATUS_BITS)
  ) u_queue_latch (
    .clock      (CLOCK),
    .rst_n      (RST_N),
    .set_bits   (queue_set),
    .clear_bits (queue_clear),
    .status     (queue_status)
  );

  // ==========================================================================
  // Interrupt.
  // ==========================================================================
  // One level output for both groups, held while any enabled bit is set.
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= (|(hdr_status & hdr_enable)) |
             (|(queue_status & queue_enable));
    end
  end

  // ==========================================================================
  // AXI4-Lite read path.
  // ==========================================================================
  // One read at a time; the address is refused while data waits.
  assign ARREADY = !RVALID;
  assign do_read = ARVALID && ARREADY;
  assign r_idx   = ARADDR[`SRQ_ADDR_W-1:`SRQ_IDX_LSB];

  // Register read mux; unused upper bits read as zero.
  always_comb begin
    next_rdata = 32'h0000_0000;
    r_hit      = 1'b1;
    case (r_idx)
      `SRQ_IDX_ABORT_TOP:    next_rdata[7:0] = abort_snapshot[31:24];
      `SRQ_IDX_SNAP_CTRL:    next_rdata[0]   = snap_request;
      `SRQ_IDX_SNAP_DONE:    next_rdata[0]   = snap_done;
      `SRQ_IDX_HDR_STATUS:   next_rdata[3:0] = hdr_status;
      `SRQ_IDX_HDR_ENABLE:   next_rdata[3:0] = hdr_enable;
      `SRQ_IDX_LOW_WM:       next_rdata[7:0] = low_wm_reg;
      `SRQ_IDX_HIGH_WM:      next_rdata[7:0] = high_wm_reg;
      `SRQ_IDX_QUEUE_ENABLE: next_rdata[3:0] = queue_enable;
      `SRQ_IDX_QUEUE_STATUS: next_rdata[3:0] = queue_status;
      `SRQ_IDX_STATUS_CLEAR: next_rdata      = 32'h0000_0000;
      default:               r_hit           = 1'b0;
    endcase
  end

  // Read data is registered at the address handshake, so the value seen is
  // the one that the same-cycle clear wipes.
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      RVALID <= 1'b0;
      RDATA  <= 32'h0000_0000;
      RRESP  <= `SRQ_RESP_OKAY;
    end else if (do_read) begin
      RVALID <= 1'b1;
      RDATA  <= next_rdata;
      RRESP  <= r_hit ? `SRQ_RESP_OKAY : `SRQ_RESP_SLVERR;
    end else if (RREADY) begin
      RVALID <= 1'b0;
    end
  end

endmodule : srq_top

//--- design/srq_regs.svh
// Register indices, field positions and reset values of the serial receive stats and queue watermark bank.
//
// Functional notes
// - Count aborted receive bytes, show top byte.
// - Extra dropped bytes may also be counted.
// - Rising update bit snapshots and restarts counters.
// - Done set after snapshot, cleared by zero.
// - Latch SAPI high mismatch, clear on read.
// - Latch SAPI low mismatch, clear on read.
// - Latch control field mismatch, clear on read.
// - Latch address field mismatch, clear on read.
// - Header mismatch bits interrupt only when enabled.
// - Low watermark equals value times 65536 bytes.
// - High watermark equals value times 65536 bytes.
// - Watermarked queue holds serial-to-Ethernet data.
// - Latch HDLC-to-SDRAM FIFO overflow, clear on read.
// - Latch transmit queue overflow, clear on read.
// - Latch high watermark crossing, clear on read.
// - Latch low watermark crossing, clear on read.
// - Queue status bits interrupt only when enabled.
`ifndef SRQ_REGS_SVH
`define SRQ_REGS_SVH

// ==========================================================================
// Register indices; the byte address is four times the index.
// ==========================================================================
`define SRQ_IDX_ABORT_TOP     10'h11F
`define SRQ_IDX_SNAP_CTRL     10'h120
`define SRQ_IDX_SNAP_DONE     10'h121
`define SRQ_IDX_HDR_STATUS    10'h122
`define SRQ_IDX_HDR_ENABLE    10'h123
`define SRQ_IDX_LOW_WM        10'h124
`define SRQ_IDX_HIGH_WM       10'h125
`define SRQ_IDX_QUEUE_ENABLE  10'h126
`define SRQ_IDX_QUEUE_STATUS  10'h127
`define SRQ_IDX_STATUS_CLEAR  10'h128

// ==========================================================================
// Widths, fields and reset values.
// ==========================================================================
`define SRQ_ADDR_W            12
`define SRQ_IDX_LSB           2
`define SRQ_REG_RESET         8'h00
`define SRQ_COUNT_RESET       32'h0000_0000
`define SRQ_WM_SHIFT          16
`define SRQ_CLEAR_HDR_LSB     0
`define SRQ_CLEAR_QUEUE_LSB   4
`define SRQ_STATUS_BITS       4
`define SRQ_RESP_OKAY         2'h0
`define SRQ_RESP_SLVERR       2'h2

`endif

//--- design/srq_pkg.sv
// Types shared by the serial receive stats and queue watermark bank.
package srq_pkg;

  // ==========================================================================
  // Received or expected X.86 header fields, one octet each.
  // ==========================================================================
  typedef struct packed {
    logic [7:0] sapi_high;
    logic [7:0] sapi_low;
    logic [7:0] control;
    logic [7:0] address;
  } srq_x86_hdr_t;

  // Four sticky status bits in register bit order 3 down to 0.
  typedef logic [3:0] srq_status_t;

  // Snapshot sequencer states, one-hot.
  typedef enum logic [2:0] {
    SRQ_SNAP_IDLE = 3'b001,
    SRQ_SNAP_DONE = 3'b010,
    SRQ_SNAP_WAIT = 3'b100
  } srq_snap_state_t;

endpackage : srq_pkg

//--- design/srq_event_latch.sv
// Sticky status bits with clear pulses where a new event outranks the clear.
`timescale 1ns/10ps
module srq_event_latch
  import srq_pkg::*;
#(
  parameter int W = 4
) (
  // Clock and reset.
  input  wire logic         clock,
  input  wire logic         rst_n,
  // Events and clears.
  input  wire logic [W-1:0] set_bits,
  input  wire logic [W-1:0] clear_bits,
  // Sticky state.
  output logic      [W-1:0] status
);

  // ==========================================================================
  // Sticky bits.
  // ==========================================================================
  // An event in the same cycle as its clear stays set, so nothing is lost
  // when software reads just as the event lands.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      status <= '0;
    end else begin
      status <= (status & ~clear_bits) | set_bits;
    end
  end

endmodule : srq_event_latch

//--- verif/srq_top_sva.sv
// Checker of bus handshakes, read width and interrupt reset for the register bank.
`timescale 1ns/10ps
module srq_top_sva (
  // Clock and reset.
  input wire logic        CLOCK,
  input wire logic        RST_N,
  // Bus handshakes.
  input wire logic        AWVALID,
  input wire logic        AWREADY,
  input wire logic        WVALID,
  input wire logic        WREADY,
  input wire logic        BVALID,
  input wire logic        BREADY,
  input wire logic        ARVALID,
  input wire logic        ARREADY,
  input wire logic        RVALID,
  input wire logic        RREADY,
  input wire logic [31:0] RDATA,
  // Interrupt.
  input wire logic        IRQ
);
  // ==========================================================================
  // Assertions, all in the one clock domain.
  // ==========================================================================
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N);

  AST_RD_LAT: assert property (ARVALID && ARREADY |=> RVALID)
    else $error("read data did not follow the address");
  AST_WR_LAT: assert property (AWVALID && AWREADY && WVALID && WREADY |-> ##[1:3] BVALID)
    else $error("write response late");
  AST_AR_BLOCK: assert property (RVALID |-> !ARREADY)
    else $error("read address taken while data pending");
  AST_W_BLOCK: assert property (BVALID |-> !AWREADY && !WREADY)
    else $error("write taken while response pending");
  AST_B_DROP: assert property (BVALID && BREADY |=> !BVALID)
    else $error("write response repeated");
  AST_R_DROP: assert property (RVALID && RREADY |=> !RVALID)
    else $error("read data repeated");
  AST_RDATA_TOP: assert property (RVALID |-> RDATA[31:8] == 24'h00_0000)
    else $error("upper read bits not zero");
  AST_RST_IRQ: assert property ($rose(RST_N) |-> !IRQ)
    else $error("interrupt high after reset");
endmodule : srq_top_sva

//--- verif/srq_top_test.sv
// Self-checking testbench of the register bank.
`timescale 1ns/10ps
module srq_top_test
  import srq_pkg::*;
;
  // ==========================================================================
  // Stimulus, observed outputs and the bench's model state.
  // ==========================================================================
  logic [11:0]  AWADDR = '0, ARADDR = '0;
  logic [31:0]  WDATA = '0, RDATA, d;
  logic [3:0]   WSTRB = 4'hF;
  logic         CLOCK = 0, RST_N = 0, AWVALID = 0, WVALID = 0, BREADY = 0, ARVALID = 0, RREADY = 0;
  logic         ABORT_BYTE = 0, HDR_VALID = 0, HDLC_FIFO_OVERFLOW = 0, QUEUE_OVERFLOW = 0;
  srq_x86_hdr_t HDR_RX = '0, HDR_EXPECTED = '0;
  logic [23:0]  QUEUE_FILL = '0;
  logic         AWREADY, WREADY, BVALID, ARREADY, RVALID, IRQ;
  logic [1:0]   BRESP, RRESP, r;
  logic [7:0]   en;
  int           n_fail = 0, total_checks = 0;
  int           regs[7] = '{'h11F, 'h120, 'h121, 'h123, 'h124, 'h125, 'h126};
  int           fills[5] = '{65535, 65536, 131071, 131072, 0};
  int           fexp[5] = '{0, 1, 0, 2, 3};
  int           ks[6] = '{0, 1, 2, 3, 6, 7};

  srq_top #(.FILL_W(24)) dut (.*);

  always #4 CLOCK = ~CLOCK;

  // Compare and count; a mismatch is printed at once.
  task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", s, exp, seen);
    end
  endtask : chk

  // One bus cycle; each channel is released only at the edge that takes it.
  task automatic bus(input bit w, input logic [9:0] i, input logic [7:0] v);
    logic a, b, c, f;
    @(posedge CLOCK);
    if (w) begin
      AWADDR <= {i, 2'b00};
      WDATA <= {24'h00_0000, v};
      AWVALID <= 1;
      WVALID <= 1;
      BREADY <= 1;
    end else begin
      ARADDR <= {i, 2'b00};
      ARVALID <= 1;
      RREADY <= 1;
    end
    do begin
      @(negedge CLOCK);
      a = AWVALID && AWREADY;
      b = WVALID && WREADY;
      c = ARVALID && ARREADY;
      f = (BVALID && BREADY) || (RVALID && RREADY);
      d = RDATA;
      r = w ? BRESP : RRESP;
      @(posedge CLOCK);
      if (a) AWVALID <= 0;
      if (b) WVALID <= 0;
      if (c) ARVALID <= 0;
    end while (!f);
    BREADY <= 0;
    RREADY <= 0;
    // Unmapped places answer with an error code.
    chk("resp", r, (i >= 10'h11F && i <= 10'h128) ? 2'h0 : 2'h2);
  endtask : bus

  task automatic rd(input logic [9:0] i, input logic [31:0] e);
    bus(0, i, 8'h00);
    chk("rdata", d, e);
  endtask : rd

  // Raise one event for one cycle; 0..3 header fields, 6 queue, 7 FIFO overflow.
  task automatic ev(input int k);
    logic [31:0] x;
    x = $urandom;
    @(posedge CLOCK);
    HDR_EXPECTED <= x;
    HDR_RX <= x ^ (32'(($urandom % 255) + 1) << (8 * (k % 4)));
    HDR_VALID <= (k < 4);
    QUEUE_OVERFLOW <= (k == 6);
    HDLC_FIFO_OVERFLOW <= (k == 7);
    @(posedge CLOCK);
    HDR_VALID <= 0;
    QUEUE_OVERFLOW <= 0;
    HDLC_FIFO_OVERFLOW <= 0;
    repeat (2) @(posedge CLOCK);
    @(negedge CLOCK);
  endtask : ev

  task automatic summarize();
    $display("checks %0d errors %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : summarize

  // A hang counts as a failure; the tests need well under this span.
  initial begin
    #200000;
    n_fail++;
    summarize();
  end

  // ==========================================================================
  // Main sequence.
  // ==========================================================================
  initial begin
    void'($urandom(32'h233c0d47));
    repeat (5) @(posedge CLOCK);
    RST_N <= 1;
    foreach (regs[j]) rd(10'(regs[j]), 32'h0);
    rd(10'h130, 32'h0);
    bus(1, 10'h130, 8'hFF);
    // Moving both thresholds above an empty queue is itself a crossing.
    bus(1, 10'h124, 8'h01);
    bus(1, 10'h125, 8'h02);
    // A write without byte lane 0 must store nothing.
    WSTRB <= 4'hE;
    bus(1, 10'h124, 8'h55);
    WSTRB <= 4'hF;
    rd(10'h124, 32'h1);
    rd(10'h125, 32'h2);
    rd(10'h127, 32'h3);
    foreach (fills[j]) begin
      @(posedge CLOCK);
      QUEUE_FILL <= 24'(fills[j]);
      repeat (2) @(posedge CLOCK);
      rd(10'h127, 32'(fexp[j]));
    end
    foreach (ks[j]) begin
      en = 8'($urandom);
      bus(1, 10'h123, {4'h0, en[3:0]});
      bus(1, 10'h126, {4'h0, en[7:4]});
      rd(10'h126, {28'h0, en[7:4]});
      ev(ks[j]);
      chk("irq", IRQ, 32'(en[ks[j] % 4 + (ks[j] > 3 ? 4 : 0)]));
      rd(ks[j] < 4 ? 10'h122 : 10'h127, 32'h1 << (ks[j] % 4));
      rd(ks[j] < 4 ? 10'h122 : 10'h127, 32'h0);
      @(negedge CLOCK);
      chk("irq", IRQ, 32'h0);
    end
    // The clear register drops only the bits written as one.
    ev(1);
    ev(2);
    bus(1, 10'h128, 8'h04);
    rd(10'h122, 32'h2);
    ev(6);
    ev(7);
    bus(1, 10'h128, 8'h80);
    rd(10'h127, 32'h4);
    // An event landing on the clearing read's handshake edge survives it.
    fork
      rd(10'h122, 32'h0);
      begin
        @(posedge CLOCK);
        HDR_VALID <= 1;
        HDR_RX <= HDR_EXPECTED ^ 32'h0000_0001;
        @(posedge CLOCK);
        HDR_VALID <= 0;
      end
    join
    rd(10'h122, 32'h1);
    repeat (3) begin
      @(posedge CLOCK);
      ABORT_BYTE <= 1;
      @(posedge CLOCK);
      ABORT_BYTE <= 0;
    end
    bus(1, 10'h120, 8'h01);
    rd(10'h121, 32'h1);
    rd(10'h11F, 32'h0);
    bus(1, 10'h120, 8'h00);
    rd(10'h121, 32'h0);
    summarize();
  end
endmodule : srq_top_test

bind srq_top srq_top_sva u_sva (.CLOCK, .RST_N, .AWVALID, .AWREADY, .WVALID, .WREADY, .BVALID, .BREADY,
  .ARVALID, .ARREADY, .RVALID, .RREADY, .RDATA, .IRQ);
